/* File: hdl/mmx_exec.sv */
// Contract
// - post-decrement read loads working register from pointer address, then pointer minus one
// - post-increment read loads working register from pointer address, then pointer plus one
// - even pair number selects program memory, odd selects external data memory
// - pre-decrement write steps pointer down first, then stores source at new address
// - pre-increment write steps pointer up first, then stores source at new address
// - source location never modified; only destination and pointer change
// - memory transfers, word move and dispatch leave all flags unchanged
// - word move copies 16 bits from pair, indirect or immediate in 8 cycles
// - multiply even destination register by source, unsigned, 16-bit product, 22 cycles
// - multiply flags: carry above 255, zero, sign from msb, overflow cleared
// - dispatch loads program counter from word at pointer, then pointer plus two
//
// Purpose: executes memory transfer, word move, multiply and dispatch instructions
// Assumes: operands are written before the opcode; the memory partner answers with mem_ack
// Notes: busy time is the documented cycle count, one cycle more for post-decrement and post-increment reads, or longer when memory is slow
//
// Chosen here: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`include "mmx_map.svh"
module mmx_exec
  import mmx_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic [7:0]  bus_addr,
  input  wire logic [7:0]  bus_wdata,
  input  wire logic        bus_wr,
  input  wire logic        bus_rd,
  output logic      [7:0]  bus_rdata,
  output logic             mem_req,
  output logic             mem_we,
  output logic             mem_xdata,
  output logic      [15:0] mem_addr,
  output logic      [7:0]  mem_wdata,
  input  wire logic        mem_ack,
  input  wire logic [7:0]  mem_rdata
);
  logic [1:0]  rst_sync_r;
  logic        rst_n;
  mmx_state_e  state_r;
  mmx_byte_t   op_r;
  mmx_byte_t   opa_r;
  mmx_byte_t   opb_r;
  mmx_byte_t   opc_r;
  mmx_byte_t   rp_r;
  mmx_byte_t   rf_addr_r;
  mmx_byte_t   flags_r;
  mmx_word_t   pc_r;
  mmx_word_t   ip_r;
  mmx_word_t   ptr_r;
  mmx_word_t   base_ptr_r;
  mmx_byte_t   a1_r;
  mmx_byte_t   a2_r;
  mmx_byte_t   data_r;
  mmx_byte_t   nx_hi_r;
  logic        nx_lo_r;
  logic [1:0]  wb_idx_r;
  logic [5:0]  cyc_r;
  logic        done_r;
  logic        bad_r;
  mmx_byte_t   cur_op;
  logic        busy;
  logic        reg_wr;
  logic        start;
  logic        is_ld;
  logic        is_st;
  logic        is_lw;
  logic        is_mu;
  logic        is_nx;
  logic        is_ind;
  logic        step_dn;
  logic        need_a2;
  mmx_byte_t   pair_base;
  mmx_byte_t   wpair;
  logic        rf_we;
  mmx_byte_t   rf_waddr;
  mmx_byte_t   rf_wdata;
  mmx_byte_t   rf_raddr;
  mmx_byte_t   rf_q;
  logic        mul_go;
  logic        mul_done;
  mmx_word_t   mul_prod;
  logic        mul_fin;
  logic        nx_fin;

  // pointer step over the whole pair
  function automatic mmx_word_t step16(input mmx_word_t v, input logic dn);
    step16 = dn ? v - `MMX_ONE16 : v + `MMX_ONE16;
  endfunction

  // next register address
  function automatic mmx_byte_t nxt8(input mmx_byte_t a);
    nxt8 = a + `MMX_ONE8;
  endfunction

  // working register number to register file address
  function automatic mmx_byte_t wreg(input logic [3:0] n, input mmx_byte_t rp);
    wreg = {rp[`MMX_RP_FLD], n};
  endfunction

  // documented length of each opcode, zero for foreign ones
  function automatic logic [5:0] cyc_of(input mmx_byte_t op);
    case (op)
      `MMX_OP_RD_DEC, `MMX_OP_RD_INC: cyc_of = `MMX_CYC_RD;
      `MMX_OP_WR_DEC, `MMX_OP_WR_INC: cyc_of = `MMX_CYC_WR;
      `MMX_OP_LW_RR, `MMX_OP_LW_IR, `MMX_OP_LW_IM: cyc_of = `MMX_CYC_LW;
      `MMX_OP_MU_R, `MMX_OP_MU_IR, `MMX_OP_MU_IM: cyc_of = `MMX_CYC_MU;
      `MMX_OP_NEXT: cyc_of = `MMX_CYC_NX;
      default: cyc_of = 6'h00;
    endcase
  endfunction

  // reset release through two flops
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'h1};
    end
  end
  assign rst_n = rst_sync_r[1];

  // opcode class decode, live opcode while idle
  assign busy      = (state_r != S_IDLE);
  assign cur_op    = busy ? op_r : bus_wdata;
  assign is_ld     = (cur_op == `MMX_OP_RD_DEC) || (cur_op == `MMX_OP_RD_INC);
  assign is_st     = (cur_op == `MMX_OP_WR_DEC) || (cur_op == `MMX_OP_WR_INC);
  assign is_lw     = (cur_op == `MMX_OP_LW_RR) || (cur_op == `MMX_OP_LW_IR) || (cur_op == `MMX_OP_LW_IM);
  assign is_mu     = (cur_op == `MMX_OP_MU_R) || (cur_op == `MMX_OP_MU_IR) || (cur_op == `MMX_OP_MU_IM);
  assign is_nx     = (cur_op == `MMX_OP_NEXT);
  assign is_ind    = (cur_op == `MMX_OP_LW_IR) || (cur_op == `MMX_OP_MU_IR);
  assign step_dn   = ~cur_op[`MMX_STEP_BIT];
  assign need_a2   = is_st || (is_mu && (cur_op != `MMX_OP_MU_IM));
  assign pair_base = wreg(opa_r[`MMX_RR_FLD] & `MMX_EVEN_MASK, rp_r);
  assign reg_wr    = bus_wr && !busy;
  assign start     = reg_wr && (bus_addr == `MMX_A_CMD) && (cyc_of(bus_wdata) != 6'h00);
  assign mul_go    = (state_r == S_EXE) && is_mu;
  assign mul_fin   = (state_r == S_MUL) && mul_done;
  assign nx_fin    = (state_r == S_MWAIT) && mem_ack && is_nx && nx_lo_r;

  // destination pair of the write-back
  always_comb begin
    if (is_ld || is_st) begin
      wpair = pair_base;
    end else if (cur_op == `MMX_OP_LW_IM) begin
      wpair = opa_r;
    end else begin
      wpair = opb_r;
    end
  end

  // register file port: sequencer while busy, software while idle
  always_comb begin
    case (state_r)
      S_IND:   rf_raddr = opa_r;
      S_RDH:   rf_raddr = a1_r;
      S_RDL:   rf_raddr = nxt8(a1_r);
      S_RDX:   rf_raddr = a2_r;
      default: rf_raddr = rf_addr_r;
    endcase
    rf_we    = reg_wr && (bus_addr == `MMX_A_RFD);
    rf_waddr = rf_addr_r;
    rf_wdata = bus_wdata;
    if (state_r == S_WB) begin
      rf_we = 1'h1;
      case (wb_idx_r)
        `MMX_WB_DST: begin
          rf_waddr = wreg(opa_r[`MMX_R_FLD], rp_r);
          rf_wdata = data_r;
        end
        `MMX_WB_HI: begin
          rf_waddr = wpair;
          rf_wdata = ptr_r[15:8];
        end
        default: begin
          rf_waddr = nxt8(wpair);
          rf_wdata = ptr_r[7:0];
        end
      endcase
    end
  end

  // instruction sequencer and memory request
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r    <= S_IDLE;
      op_r       <= 8'h00;
      ptr_r      <= 16'h0000;
      base_ptr_r <= 16'h0000;
      a1_r       <= 8'h00;
      a2_r       <= 8'h00;
      data_r     <= 8'h00;
      nx_hi_r    <= 8'h00;
      nx_lo_r    <= 1'h0;
      wb_idx_r   <= `MMX_WB_DST;
      cyc_r      <= 6'h00;
      mem_req    <= 1'h0;
      mem_we     <= 1'h0;
      mem_xdata  <= 1'h0;
      mem_addr   <= 16'h0000;
      mem_wdata  <= 8'h00;
    end else begin
      if (busy && (cyc_r != `MMX_CYC_MAX)) begin
        cyc_r <= cyc_r + 6'h01;
      end
      case (state_r)
        S_IDLE: begin
          if (start) begin
            op_r     <= bus_wdata;
            cyc_r    <= 6'h00;
            nx_lo_r  <= 1'h0;
            wb_idx_r <= is_ld ? `MMX_WB_DST : `MMX_WB_HI;
            a1_r     <= (is_ld || is_st) ? pair_base : (is_mu ? opb_r : opa_r);
            a2_r     <= is_st ? wreg(opa_r[`MMX_R_FLD], rp_r) : opa_r;
            if (bus_wdata == `MMX_OP_LW_IM) begin
              ptr_r   <= {opb_r, opc_r};
              state_r <= S_WB;
            end else if (is_nx) begin
              ptr_r      <= ip_r;
              base_ptr_r <= ip_r;
              state_r    <= S_MEM;
            end else if (is_ind) begin
              state_r <= S_IND;
            end else begin
              state_r <= S_RDH;
            end
          end
        end
        S_IND:   state_r <= S_INDC;
        S_INDC: begin
          if (is_mu) begin
            a2_r <= rf_q;
          end else begin
            a1_r <= rf_q;
          end
          state_r <= S_RDH;
        end
        S_RDH:   state_r <= S_RDL;
        S_RDL: begin
          ptr_r[15:8] <= rf_q;
          state_r     <= S_RDX;
        end
        S_RDX: begin
          ptr_r[7:0] <= rf_q;
          base_ptr_r <= {ptr_r[15:8], rf_q};
          if (is_lw) begin
            state_r <= S_WB;
          end else if (need_a2) begin
            state_r <= S_CAPX;
          end else begin
            state_r <= S_EXE;
          end
        end
        S_CAPX: begin
          data_r  <= rf_q;
          state_r <= S_EXE;
        end
        S_EXE: begin
          if (is_st) begin
            ptr_r <= step16(ptr_r, step_dn);
          end
          state_r <= is_mu ? S_MUL : S_MEM;
        end
        S_MEM: begin
          mem_req   <= 1'h1;
          mem_we    <= is_st;
          mem_xdata <= is_nx ? 1'h0 : opa_r[`MMX_SPACE_BIT];
          mem_addr  <= ptr_r;
          mem_wdata <= data_r;
          state_r   <= S_MWAIT;
        end
        S_MWAIT: begin
          if (mem_ack) begin
            mem_req <= 1'h0;
            mem_we  <= 1'h0;
            if (is_nx) begin
              if (!nx_lo_r) begin
                nx_hi_r <= mem_rdata;
                ptr_r   <= step16(ptr_r, 1'h0);
                nx_lo_r <= 1'h1;
                state_r <= S_MEM;
              end else begin
                state_r <= S_FIN;
              end
            end else begin
              if (is_ld) begin
                data_r <= mem_rdata;
                ptr_r  <= step16(ptr_r, step_dn);
              end
              state_r <= S_WB;
            end
          end
        end
        S_MUL: begin
          if (mul_done) begin
            ptr_r   <= mul_prod;
            state_r <= S_WB;
          end
        end
        S_WB: begin
          wb_idx_r <= wb_idx_r + 2'h1;
          if (wb_idx_r == `MMX_WB_LO) begin
            state_r <= S_FIN;
          end
        end
        S_FIN: begin
          if (cyc_r >= cyc_of(op_r) - 6'h01) begin
            state_r <= S_IDLE;
          end
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end

  // flags, program counter and dispatch pointer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flags_r <= 8'h00;
      pc_r    <= 16'h0000;
      ip_r    <= 16'h0000;
    end else if (mul_fin) begin
      flags_r[`MMX_F_C] <= (mul_prod > `MMX_BYTE_MAX);
      flags_r[`MMX_F_Z] <= (mul_prod == 16'h0000);
      flags_r[`MMX_F_S] <= mul_prod[15];
      flags_r[`MMX_F_V] <= 1'h0;
    end else if (nx_fin) begin
      pc_r <= {nx_hi_r, mem_rdata};
      ip_r <= ip_r + `MMX_IP_STEP;
    end else if (reg_wr) begin
      case (bus_addr)
        `MMX_A_FLAGS: flags_r <= bus_wdata;
        `MMX_A_PCH:   pc_r    <= {bus_wdata, pc_r[7:0]};
        `MMX_A_PCL:   pc_r    <= {pc_r[15:8], bus_wdata};
        `MMX_A_IPH:   ip_r    <= {bus_wdata, ip_r[7:0]};
        `MMX_A_IPL:   ip_r    <= {ip_r[15:8], bus_wdata};
        default:      ;
      endcase
    end
  end

  // operand, window and status registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      opa_r     <= 8'h00;
      opb_r     <= 8'h00;
      opc_r     <= 8'h00;
      rp_r      <= 8'h00;
      rf_addr_r <= 8'h00;
      done_r    <= 1'h0;
      bad_r     <= 1'h0;
    end else begin
      if ((state_r == S_FIN) && (cyc_r >= cyc_of(op_r) - 6'h01)) begin
        done_r <= 1'h1;
      end
      if (reg_wr) begin
        case (bus_addr)
          `MMX_A_CMD: begin
            done_r <= 1'h0;
            bad_r  <= !start;
          end
          `MMX_A_OPA: opa_r     <= bus_wdata;
          `MMX_A_OPB: opb_r     <= bus_wdata;
          `MMX_A_OPC: opc_r     <= bus_wdata;
          `MMX_A_RP:  rp_r      <= bus_wdata;
          `MMX_A_RFA: rf_addr_r <= bus_wdata;
          default:    ;
        endcase
      end
    end
  end

  // read data for the cycle after a read strobe
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_rdata <= 8'h00;
    end else if (bus_rd) begin
      case (bus_addr)
        `MMX_A_OPA:   bus_rdata <= opa_r;
        `MMX_A_OPB:   bus_rdata <= opb_r;
        `MMX_A_OPC:   bus_rdata <= opc_r;
        `MMX_A_FLAGS: bus_rdata <= flags_r;
        `MMX_A_RP:    bus_rdata <= rp_r;
        `MMX_A_PCH:   bus_rdata <= pc_r[15:8];
        `MMX_A_PCL:   bus_rdata <= pc_r[7:0];
        `MMX_A_IPH:   bus_rdata <= ip_r[15:8];
        `MMX_A_IPL:   bus_rdata <= ip_r[7:0];
        `MMX_A_STAT:  bus_rdata <= {5'h00, bad_r, done_r, busy};
        `MMX_A_RFA:   bus_rdata <= rf_addr_r;
        `MMX_A_RFD:   bus_rdata <= rf_q;
        default:      bus_rdata <= 8'h00;
      endcase
    end else begin
      bus_rdata <= 8'h00;
    end
  end

  mmx_rf #(
    .AW (8),
    .DW (8)
  ) u_rf (
    .clk   (clk),
    .rst_n (rst_n),
    .we    (rf_we),
    .waddr (rf_waddr),
    .wdata (rf_wdata),
    .raddr (rf_raddr),
    .rdata (rf_q)
  );

  mmx_mul #(
    .W (8)
  ) u_mul (
    .clk   (clk),
    .rst_n (rst_n),
    .go    (mul_go),
    .a     (ptr_r[15:8]),
    .b     ((cur_op == `MMX_OP_MU_IM) ? opa_r : data_r),
    .done  (mul_done),
    .prod  (mul_prod)
  );

  // checker helpers
  mmx_word_t mu_ref_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mu_ref_r <= 16'h0000;
    end else if (mul_go) begin
      mu_ref_r <= {8'h00, ptr_r[15:8]} * {8'h00, ((cur_op == `MMX_OP_MU_IM) ? opa_r : data_r)};
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_rd_dec;
    (state_r == S_FIN) && ($past(state_r) == S_WB) && (op_r == `MMX_OP_RD_DEC)
      |-> (ptr_r == base_ptr_r - `MMX_ONE16) && (mem_addr == base_ptr_r);
  endproperty
  a_rd_dec: assert property (p_rd_dec) else $error("post-decrement pointer wrong");
  property p_rd_inc;
    (state_r == S_FIN) && ($past(state_r) == S_WB) && (op_r == `MMX_OP_RD_INC)
      |-> (ptr_r == base_ptr_r + `MMX_ONE16) && (mem_addr == base_ptr_r);
  endproperty
  a_rd_inc: assert property (p_rd_inc) else $error("post-increment pointer wrong");
  property p_space;
    $rose(mem_req) |-> (mem_xdata == (is_nx ? 1'h0 : opa_r[`MMX_SPACE_BIT]));
  endproperty
  a_space: assert property (p_space) else $error("memory space select wrong");
  property p_wr_dec;
    $rose(mem_req) && (op_r == `MMX_OP_WR_DEC) |-> mem_we && (mem_addr == base_ptr_r - `MMX_ONE16);
  endproperty
  a_wr_dec: assert property (p_wr_dec) else $error("pre-decrement address wrong");
  property p_wr_inc;
    $rose(mem_req) && (op_r == `MMX_OP_WR_INC) |-> mem_we && (mem_addr == base_ptr_r + `MMX_ONE16);
  endproperty
  a_wr_inc: assert property (p_wr_inc) else $error("pre-increment address wrong");
  property p_src_kept;
    mem_req && mem_we |-> is_st;
  endproperty
  a_src_kept: assert property (p_src_kept) else $error("memory written by a load");
  property p_flags_kept;
    (busy && !is_mu) ##1 busy |-> $stable(flags_r);
  endproperty
  a_flags_kept: assert property (p_flags_kept) else $error("flags changed");
  property p_lw_len;
    $rose(busy) && is_lw |-> busy [*8] ##1 !busy;
  endproperty
  a_lw_len: assert property (p_lw_len) else $error("word move length wrong");
  property p_mu_len;
    $rose(busy) && is_mu |-> ##21 busy ##1 !busy;
  endproperty
  a_mu_len: assert property (p_mu_len) else $error("multiply length wrong");
  property p_mu_val;
    mul_fin |=> (ptr_r == mu_ref_r) && (flags_r[`MMX_F_C] == (mu_ref_r > `MMX_BYTE_MAX));
  endproperty
  a_mu_val: assert property (p_mu_val) else $error("product or carry wrong");
  property p_mu_flags;
    mul_fin |=> !flags_r[`MMX_F_V] && $stable(flags_r[`MMX_F_D]) && $stable(flags_r[`MMX_F_H])
      && (flags_r[`MMX_F_Z] == (ptr_r == 16'h0000)) && (flags_r[`MMX_F_S] == ptr_r[15]);
  endproperty
  a_mu_flags: assert property (p_mu_flags) else $error("multiply flags wrong");
  property p_nx;
    $fell(busy) && (op_r == `MMX_OP_NEXT)
      |-> (ip_r == base_ptr_r + `MMX_IP_STEP) && (pc_r[15:8] == nx_hi_r) && (mem_addr == base_ptr_r + `MMX_ONE16);
  endproperty
  a_nx: assert property (p_nx) else $error("dispatch result wrong");

  property p_cov_ld;
    $rose(busy) && is_ld;
  endproperty
  c_cov_ld: cover property (p_cov_ld);
  property p_cov_st;
    $rose(mem_req) && mem_we;
  endproperty
  c_cov_st: cover property (p_cov_st);
  property p_cov_mu;
    mul_fin && (mul_prod > `MMX_BYTE_MAX);
  endproperty
  c_cov_mu: cover property (p_cov_mu);
  property p_cov_nx;
    nx_fin;
  endproperty
  c_cov_nx: cover property (p_cov_nx);
endmodule // mmx_exec

/* File: hdl/mmx_map.svh */
// Purpose: offsets, opcodes, field positions and cycle counts of the executor
// Assumes: included by bare name from every design file that needs it
// Notes: definitions only
`ifndef MMX_MAP_SVH
`define MMX_MAP_SVH

// register port byte addresses
`define MMX_A_CMD     8'h00
`define MMX_A_OPA     8'h01
`define MMX_A_OPB     8'h02
`define MMX_A_OPC     8'h03
`define MMX_A_FLAGS   8'h04
`define MMX_A_RP      8'h05
`define MMX_A_PCH     8'h06
`define MMX_A_PCL     8'h07
`define MMX_A_IPH     8'h08
`define MMX_A_IPL     8'h09
`define MMX_A_STAT    8'h0A
`define MMX_A_RFA     8'h0B
`define MMX_A_RFD     8'h0C

// opcodes executed here
`define MMX_OP_RD_DEC 8'hE2
`define MMX_OP_RD_INC 8'hE3
`define MMX_OP_WR_DEC 8'hF2
`define MMX_OP_WR_INC 8'hF3
`define MMX_OP_LW_RR  8'hC4
`define MMX_OP_LW_IR  8'hC5
`define MMX_OP_LW_IM  8'hC6
`define MMX_OP_MU_R   8'h84
`define MMX_OP_MU_IR  8'h85
`define MMX_OP_MU_IM  8'h86
`define MMX_OP_NEXT   8'h0F

// instruction lengths in clock cycles
`define MMX_CYC_RD    6'h0A
`define MMX_CYC_WR    6'h0E
`define MMX_CYC_LW    6'h08
`define MMX_CYC_MU    6'h16
`define MMX_CYC_NX    6'h0A
`define MMX_CYC_MAX   6'h3F

// field positions
`define MMX_STEP_BIT  0
`define MMX_SPACE_BIT 0
`define MMX_R_FLD     7:4
`define MMX_RR_FLD    3:0
`define MMX_RP_FLD    7:4
`define MMX_EVEN_MASK 4'hE
`define MMX_F_C       7
`define MMX_F_Z       6
`define MMX_F_S       5
`define MMX_F_V       4
`define MMX_F_D       3
`define MMX_F_H       2
`define MMX_ST_BUSY   0
`define MMX_ST_DONE   1
`define MMX_ST_BAD    2

// write-back slots and arithmetic steps
`define MMX_WB_DST    2'h0
`define MMX_WB_HI     2'h1
`define MMX_WB_LO     2'h2
`define MMX_ONE16     16'h0001
`define MMX_IP_STEP   16'h0002
`define MMX_BYTE_MAX  16'h00FF
`define MMX_ONE8      8'h01
`endif

/* File: hdl/mmx_pkg.sv */
// Purpose: shared types of the executor
// Assumes: nothing
// Notes: constants live in mmx_map.svh
package mmx_pkg;
  typedef logic [7:0]  mmx_byte_t;
  typedef logic [15:0] mmx_word_t;
  typedef enum logic [3:0] {
    S_IDLE  = 4'b0000,
    S_IND   = 4'b0001,
    S_INDC  = 4'b0010,
    S_RDH   = 4'b0011,
    S_RDL   = 4'b0100,
    S_RDX   = 4'b0101,
    S_CAPX  = 4'b0110,
    S_EXE   = 4'b0111,
    S_MEM   = 4'b1000,
    S_MWAIT = 4'b1001,
    S_MUL   = 4'b1010,
    S_WB    = 4'b1011,
    S_FIN   = 4'b1100
  } mmx_state_e;
endpackage

/* File: hdl/mmx_rf.sv */
// Purpose: register file, one write and one registered read port
// Assumes: write and read in the same cycle to one address return old data
// Notes: contents are not reset
`timescale 1ns/1ps
module mmx_rf #(
  parameter int AW = 8,
  parameter int DW = 8
) (
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [DW-1:0] wdata,
  input  wire logic [AW-1:0] raddr,
  output logic      [DW-1:0] rdata
);
  logic [DW-1:0] mem [2**AW];

  // storage write
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // registered read
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= '0;
    end else begin
      rdata <= mem[raddr];
    end
  end
endmodule // mmx_rf

/* File: hdl/mmx_mul.sv */
// Purpose: unsigned shift-add multiplier
// Assumes: go is a one-cycle pulse while idle
// Notes: done pulses W+1 cycles after go, prod then holds a*b
`timescale 1ns/1ps
module mmx_mul #(
  parameter int W = 8
) (
  input  wire logic           clk,
  input  wire logic           rst_n,
  input  wire logic           go,
  input  wire logic [W-1:0]   a,
  input  wire logic [W-1:0]   b,
  output logic                done,
  output logic      [2*W-1:0] prod
);
  localparam int CW = $clog2(W + 1);
  logic [CW-1:0]  cnt_r;
  logic [2*W-1:0] mcand_r;
  logic [W-1:0]   mplier_r;

  // one partial product per cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      done     <= 1'h0;
      prod     <= '0;
      cnt_r    <= '0;
      mcand_r  <= '0;
      mplier_r <= '0;
    end else begin
      done <= 1'h0;
      if (go) begin
        prod     <= '0;
        mcand_r  <= {{W{1'h0}}, a};
        mplier_r <= b;
        cnt_r    <= CW'(W);
      end else if (cnt_r != '0) begin
        if (mplier_r[0]) begin
          prod <= prod + mcand_r;
        end
        mcand_r  <= mcand_r << 1;
        mplier_r <= mplier_r >> 1;
        cnt_r    <= cnt_r - CW'(1);
        done     <= (cnt_r == CW'(1));
      end
    end
  end
endmodule // mmx_mul

/* File: bench/mmx_mem_model.sv */
// Purpose: program and data memory behind the executor
// Assumes: one request at a time
// Notes: ack after slow extra cycles
`timescale 1ns/1ps
module mmx_mem_model (
  input  wire logic        clk,
  input  wire logic [1:0]  slow,
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic        mem_xdata,
  input  wire logic [15:0] mem_addr,
  input  wire logic [7:0]  mem_wdata,
  output logic             mem_ack,
  output logic      [7:0]  mem_rdata
);
  logic [7:0] m [0:131071];
  logic [1:0] cnt;
  initial begin
    mem_ack = 1'b0;
    mem_rdata = 8'h00;
    cnt = 2'h0;
  end
  // answer once per request; data toggles when not valid
  always @(posedge clk) begin
    mem_ack <= 1'b0;
    mem_rdata <= ~mem_rdata;
    cnt <= (mem_req && !mem_ack) ? cnt + 2'h1 : 2'h0;
    if (mem_req && !mem_ack && cnt == slow) begin
      mem_ack <= 1'b1;
      if (mem_we)
        m[{mem_xdata, mem_addr}] <= mem_wdata;
      else
        mem_rdata <= m[{mem_xdata, mem_addr}];
    end
  end
endmodule // mmx_mem_model

/* File: bench/memxfer_unsigned_product_op_next_exec_tb.sv */
// Purpose: self-checking bench of the executor
// Assumes: working group 0, so rN is regfile N
// Notes: reads noted in a queue, checked a cycle later
`timescale 1ns/1ps
`include "mmx_map.svh"
module memxfer_unsigned_product_op_next_exec_tb;
  logic        clk = 1'b0, rstn = 1'b0, bus_wr = 1'b0, bus_rd = 1'b0, chk = 1'b0, chk_d = 1'b0;
  logic [7:0]  bus_addr = 8'h00, bus_wdata = 8'h00, bus_rdata, mem_rdata, mem_wdata, fl, a, b;
  logic        mem_req, mem_we, mem_xdata, mem_ack;
  logic [15:0] mem_addr, p;
  logic [1:0]  slow = 2'h0;
  logic [7:0]  exp_q[$], adr_q[$];
  int          fail_count = 0, compares = 0, seed = 56, i;
  // clock
  always #2 clk = ~clk;
  mmx_exec dut (.clk(clk), .rstn(rstn), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .mem_req(mem_req),
    .mem_we(mem_we), .mem_xdata(mem_xdata), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata));
  mmx_mem_model mem (.clk(clk), .slow(slow), .mem_req(mem_req), .mem_we(mem_we),
    .mem_xdata(mem_xdata), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata));
  task automatic check(input logic [7:0] seen, e, ad);
    compares++;
    if (seen !== e) begin
      fail_count++;
      $display("FAIL loc %h exp %h seen %h", ad, e, seen);
    end
  endtask
  task automatic wr(input logic [7:0] ad, d);
    @(posedge clk);
    bus_addr <= ad;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    @(posedge clk);
    bus_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] ad, e, input logic c);
    @(posedge clk);
    bus_addr <= ad;
    bus_rd <= 1'b1;
    chk <= c;
    if (c) begin
      exp_q.push_back(e);
      adr_q.push_back(ad);
    end
    @(posedge clk);
    bus_rd <= 1'b0;
  endtask
  task automatic rfw(input logic [7:0] ad, d);
    wr(`MMX_A_RFA, ad);
    wr(`MMX_A_RFD, d);
  endtask
  task automatic rfr(input logic [7:0] ad, e);
    wr(`MMX_A_RFA, ad);
    @(posedge clk);
    rd(`MMX_A_RFD, e, 1'b1);
  endtask
  // start an op, poll status until done and idle
  task automatic run(input logic [7:0] op);
    int n;
    wr(`MMX_A_CMD, op);
    for (n = 0; n < 80; n++) begin
      rd(`MMX_A_STAT, 8'h00, 1'b0);
      #1;
      if (bus_rdata[1:0] === 2'b10)
        break;
    end
    // no done seen within the poll limit
    if (n == 80)
      fail_count++;
    $display("op %h done", op);
  endtask
  task automatic print_verdict;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // take the oldest note when read data appears
  always @(posedge clk) begin
    if (chk_d)
      check(bus_rdata, exp_q.pop_front(), adr_q.pop_front());
    chk_d <= bus_rd & chk;
  end
  // watchdog
  initial begin
    #60000;
    fail_count++;
    print_verdict;
  end
  // main sequence
  initial begin
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    fl = 8'($random(seed));
    wr(`MMX_A_FLAGS, fl);
    rfw(8'h06, 8'h10);
    rfw(8'h07, 8'h00);
    mem.m[17'h01000] = 8'hCD;
    wr(`MMX_A_OPA, 8'h86);
    run(`MMX_OP_RD_DEC);
    rfr(8'h08, 8'hCD);
    rfr(8'h06, 8'h0F);
    rfr(8'h07, 8'hFF);
    slow = 2'h2;
    mem.m[17'h10FFF] = 8'hDD;
    wr(`MMX_A_OPA, 8'h87);
    run(`MMX_OP_RD_INC);
    rfr(8'h08, 8'hDD);
    rfr(8'h06, 8'h10);
    rfr(8'h07, 8'h00);
    rfw(8'h00, 8'h77);
    wr(`MMX_A_OPA, 8'h06);
    run(`MMX_OP_WR_DEC);
    check(mem.m[17'h00FFF], 8'h77, 8'hF2);
    rfr(8'h07, 8'hFF);
    wr(`MMX_A_OPA, 8'h07);
    run(`MMX_OP_WR_INC);
    check(mem.m[17'h11000], 8'h77, 8'hF3);
    rfr(8'h00, 8'h77);
    rd(`MMX_A_FLAGS, fl, 1'b1);
    a = 8'($random(seed));
    b = 8'($random(seed));
    wr(`MMX_A_OPA, 8'h0A);
    wr(`MMX_A_OPB, a);
    wr(`MMX_A_OPC, b);
    run(`MMX_OP_LW_IM);
    rfr(8'h0A, a);
    rfr(8'h0B, b);
    // pair source, then indirect source through r0D
    rfw(8'h0D, 8'h0A);
    for (i = 0; i < 2; i++) begin
      wr(`MMX_A_OPA, i ? 8'h0D : 8'h0A);
      wr(`MMX_A_OPB, i ? 8'h12 : 8'h10);
      run(i ? `MMX_OP_LW_IR : `MMX_OP_LW_RR);
      rfr(i ? 8'h12 : 8'h10, a);
      rfr(i ? 8'h13 : 8'h11, b);
    end
    // r0C points at r02 for the indirect multiply
    rfw(8'h0C, 8'h02);
    for (i = 0; i < 3; i++) begin
      rfw(8'h00, i ? a : 8'h00);
      rfw(8'h02, b);
      wr(`MMX_A_OPA, (i == 2) ? 8'h0C : (i ? b : 8'h02));
      wr(`MMX_A_OPB, 8'h00);
      run((i == 2) ? `MMX_OP_MU_IR : (i ? `MMX_OP_MU_IM : `MMX_OP_MU_R));
      p = (i ? a : 8'h00) * b;
      rfr(8'h00, p[15:8]);
      rfr(8'h01, p[7:0]);
      rd(`MMX_A_FLAGS, {p > 16'h00FF, p == 16'h0000, p[15], 1'b0, fl[3:0]}, 1'b1);
      fl = {p > 16'h00FF, p == 16'h0000, p[15], 1'b0, fl[3:0]};
    end
    slow = 2'h0;
    mem.m[17'h012FF] = 8'hAB;
    mem.m[17'h01300] = 8'hCD;
    wr(`MMX_A_IPH, 8'h12);
    wr(`MMX_A_IPL, 8'hFF);
    run(`MMX_OP_NEXT);
    rd(`MMX_A_PCH, 8'hAB, 1'b1);
    rd(`MMX_A_PCL, 8'hCD, 1'b1);
    rd(`MMX_A_IPH, 8'h13, 1'b1);
    rd(`MMX_A_IPL, 8'h01, 1'b1);
    rd(`MMX_A_FLAGS, fl, 1'b1);
    repeat (3) @(posedge clk);
    print_verdict;
  end
endmodule // memxfer_unsigned_product_op_next_exec_tb
